// File: core/modbus_can_error_response.sv
// Functional notes
// - exception reply gives code 03 in byte0
// - bytes four to seven zero unless code 03
// - bytes 4..7: node, exc function, code, reserved
// - exception function is function with top bit
// - reply wait timeout set in milliseconds
// - timeout marks command, then next command
// - saved settings apply only after reload
// - cannot transmit: indicator flashes every 100ms
// - status query reports internal state
// - user-defined can bit rate accepted
// - frame uses set id, only when enabled
// - frame length 8, bytes one-three reserved
// - code 01 wrong node, 02 no reply
//
// Our own choices: the placing of the registers and the APB slave port.
module modbus_can_error_response #(
  parameter int ms_cycles = err_resp_pkg::MS_CYCLES // clocks per ms
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic cmd_sent, // pulse, command fully sent
  input wire logic [7:0] cmd_node, // node of sent command
  input wire logic [7:0] cmd_func, // function of sent command
  input wire logic reply_done, // pulse, complete reply frame
  input wire logic [7:0] reply_node, // reply node byte
  input wire logic [7:0] reply_func, // reply function byte
  input wire logic [7:0] reply_exc, // reply exception code
  output logic next_cmd, // pulse, send next command
  output logic cmd_timed_out, // pulse, command timed out
  input wire logic can_tx_ready, // can side takes frame
  input wire logic can_tx_fail, // level, no frame goes out
  output logic can_tx_valid, // error frame offered
  output logic can_tx_ext, // extended identifier
  output logic [28:0] can_tx_id, // error_frame_identifier
  output logic [3:0] can_tx_dlc, // data length
  output logic [63:0] can_tx_data, // byte n at bits 8n+7:8n
  output logic [19:0] can_bit_rate, // user rate, bit/s
  output logic [7:0] bit_timing_word_zero, // active timing byte 0
  output logic [7:0] bit_timing_word_one, // active timing byte 1
  output logic power_indicator_led, // high = lit
  output logic irq // level interrupt
);

  // staged settings, written by software
  logic en_stg_q, ext_stg_q;
  logic [28:0] id_stg_q;
  logic [15:0] tmo_stg_q;
  logic [19:0] rate_stg_q;
  logic [15:0] btw_stg_q;
  // active settings, used by the logic
  logic en_act_q, ext_act_q;
  logic [28:0] id_act_q;
  logic [15:0] tmo_act_q;
  logic [19:0] rate_act_q;
  logic [15:0] btw_act_q;
  // apb answer flops
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  // sequencer
  err_resp_pkg::state_t state_q, state_d;
  logic [7:0] node_q, func_q; // command under way
  logic [15:0] ms_div_q; // millisecond prescaler
  logic [15:0] ms_cnt_q; // elapsed ms in wait
  logic [7:0] last_code_q; // last reported code
  // frame flops
  logic tx_valid_q, tx_ext_q;
  logic [28:0] tx_id_q;
  logic [63:0] tx_data_q;
  logic next_q, tmo_q;
  // indicator
  logic led_q, fail_q;
  logic [7:0] flash_q;
  // interrupts
  logic [err_resp_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
  logic irq_q;

  // apb decode; one wait state, answer on second access cycle
  wire acc = psel & penable;
  wire acc_first = acc & ~pready_q;
  wire wr = acc & pready_q & pwrite;
  wire hit_ctrl = paddr == err_resp_pkg::OFF_CTRL;
  wire hit_id = paddr == err_resp_pkg::OFF_ERR_ID;
  wire hit_tmo = paddr == err_resp_pkg::OFF_TIMEOUT;
  wire hit_rate = paddr == err_resp_pkg::OFF_BIT_RATE;
  wire hit_btw = paddr == err_resp_pkg::OFF_BIT_TIMING;
  wire hit_rel = paddr == err_resp_pkg::OFF_RELOAD;
  wire hit_stat = paddr == err_resp_pkg::OFF_STATUS;
  wire hit_ist = paddr == err_resp_pkg::OFF_IRQ_STAT;
  wire hit_imk = paddr == err_resp_pkg::OFF_IRQ_MASK;
  wire mapped = hit_ctrl | hit_id | hit_tmo | hit_rate | hit_btw | hit_rel |
    hit_stat | hit_ist | hit_imk;
  wire reload = wr & hit_rel & pwdata[err_resp_pkg::RELOAD_BIT];
  wire [err_resp_pkg::IRQ_W-1:0] w1c =
    (wr & hit_ist) ? pwdata[err_resp_pkg::IRQ_W-1:0] : '0;

  // status word: what the status query returns
  wire [31:0] status_w = {8'h00, last_code_q, 12'h000, en_act_q, fail_q,
    state_q == err_resp_pkg::ST_SEND, state_q == err_resp_pkg::ST_WAIT};

  // read mux
  wire [31:0] rd_w =
    hit_ctrl ? {30'h0, ext_stg_q, en_stg_q} :
    hit_id ? {3'h0, id_stg_q} :
    hit_tmo ? {16'h0, tmo_stg_q} :
    hit_rate ? {12'h0, rate_stg_q} :
    hit_btw ? {16'h0, btw_stg_q} :
    hit_stat ? status_w :
    hit_ist ? {28'h0, irq_stat_q} :
    hit_imk ? {28'h0, irq_mask_q} : 32'h0;

  // apb answer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc_first;
      pslverr_q <= acc_first & ~mapped;
      if (acc_first) begin
        prdata_q <= rd_w;
      end
    end
  end

  // staged settings; staying inert until a reload is the point
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      en_stg_q <= err_resp_pkg::RST_EN;
      ext_stg_q <= err_resp_pkg::RST_EXT;
      id_stg_q <= err_resp_pkg::RST_ERR_ID;
      tmo_stg_q <= err_resp_pkg::RST_TIMEOUT_MS;
      rate_stg_q <= err_resp_pkg::RST_BIT_RATE;
      btw_stg_q <= err_resp_pkg::RST_BIT_TIMING;
    end else if (wr) begin
      if (hit_ctrl) begin
        en_stg_q <= pwdata[err_resp_pkg::CTRL_EN_BIT];
        ext_stg_q <= pwdata[err_resp_pkg::CTRL_EXT_BIT];
      end
      if (hit_id) begin
        id_stg_q <= pwdata[28:0];
      end
      if (hit_tmo) begin
        tmo_stg_q <= pwdata[15:0];
      end
      if (hit_rate) begin
        rate_stg_q <= pwdata[19:0];
      end
      if (hit_btw) begin
        btw_stg_q <= pwdata[15:0];
      end
    end
  end

  // active settings: loaded at reset and on reload only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      en_act_q <= err_resp_pkg::RST_EN;
      ext_act_q <= err_resp_pkg::RST_EXT;
      id_act_q <= err_resp_pkg::RST_ERR_ID;
      tmo_act_q <= err_resp_pkg::RST_TIMEOUT_MS;
      rate_act_q <= err_resp_pkg::RST_BIT_RATE;
      btw_act_q <= err_resp_pkg::RST_BIT_TIMING;
    end else if (reload) begin
      en_act_q <= en_stg_q;
      ext_act_q <= ext_stg_q;
      id_act_q <= id_stg_q;
      tmo_act_q <= tmo_stg_q;
      rate_act_q <= rate_stg_q;
      btw_act_q <= btw_stg_q;
    end
  end

  // reply classification
  wire in_wait = state_q == err_resp_pkg::ST_WAIT;
  wire in_send = state_q == err_resp_pkg::ST_SEND;
  wire node_bad = reply_node != node_q;
  wire is_exc = err_resp_pkg::fc_known(func_q) &&
    reply_func == (func_q | err_resp_pkg::EXC_FLAG);
  wire ms_tick = ms_div_q == 16'(ms_cycles - 1);
  // a zero timeout would never fire; treat it as one ms
  wire [15:0] tmo_lim = (tmo_act_q == 16'h0) ? 16'h0001 : tmo_act_q;
  wire tmo_hit = in_wait & ~reply_done & ms_tick &
    (ms_cnt_q >= tmo_lim - 16'h0001);
  wire ev = in_wait & (reply_done | tmo_hit);
  // reply beats timeout when both land together
  wire [7:0] code_w =
    reply_done ? (node_bad ? err_resp_pkg::CODE_WRONG_NODE :
      is_exc ? err_resp_pkg::CODE_EXCEPTION :
      err_resp_pkg::CODE_NONE) :
    err_resp_pkg::CODE_NO_REPLY;
  wire is_err = ev & (code_w != err_resp_pkg::CODE_NONE);
  wire do_send = is_err & en_act_q;
  // exception details only with code 03, else zeros
  wire [31:0] detail_w = (code_w == err_resp_pkg::CODE_EXCEPTION) ?
    {8'h00, reply_exc, reply_func, reply_node} : 32'h0;
  wire [28:0] id_w = ext_act_q ? id_act_q :
    (id_act_q & err_resp_pkg::STD_ID_MASK);

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      err_resp_pkg::ST_IDLE: begin
        if (cmd_sent) begin
          state_d = err_resp_pkg::ST_WAIT;
        end
      end
      err_resp_pkg::ST_WAIT: begin
        if (ev) begin
          state_d = do_send ? err_resp_pkg::ST_SEND : err_resp_pkg::ST_IDLE;
        end
      end
      err_resp_pkg::ST_SEND: begin
        if (can_tx_ready) begin
          state_d = err_resp_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // sequencer flops and reply timer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= err_resp_pkg::ST_IDLE;
      node_q <= 8'h00;
      func_q <= 8'h00;
      ms_div_q <= 16'h0000;
      ms_cnt_q <= 16'h0000;
      last_code_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q == err_resp_pkg::ST_IDLE && cmd_sent) begin
        node_q <= cmd_node;
        func_q <= cmd_func;
        ms_div_q <= 16'h0000;
        ms_cnt_q <= 16'h0000;
      end else begin
        // free-runs between commands so the indicator keeps time
        ms_div_q <= ms_tick ? 16'h0000 : ms_div_q + 16'h0001;
        if (in_wait && ms_tick) begin
          ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
      end
      if (ev) begin
        last_code_q <= code_w;
      end
    end
  end

  // error frame and command pacing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_valid_q <= 1'b0;
      tx_ext_q <= 1'b0;
      tx_id_q <= 29'h0;
      tx_data_q <= 64'h0;
      next_q <= 1'b0;
      tmo_q <= 1'b0;
    end else begin
      // proceed after a clean reply, an unreported error or a sent frame
      next_q <= (ev & ~do_send) | (in_send & can_tx_ready);
      tmo_q <= tmo_hit;
      if (do_send) begin
        tx_valid_q <= 1'b1;
        tx_ext_q <= ext_act_q;
        tx_id_q <= id_w;
        tx_data_q <= {detail_w, 24'h000000, code_w};
      end else if (in_send && can_tx_ready) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  // indicator: steady while can works, 100 ms cycle while it fails
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      led_q <= 1'b1;
      flash_q <= 8'h00;
      fail_q <= 1'b0;
    end else begin
      fail_q <= can_tx_fail;
      if (!can_tx_fail) begin
        led_q <= 1'b1;
        flash_q <= 8'h00;
      end else if (ms_tick) begin
        if (flash_q == err_resp_pkg::FLASH_HALF_MS - 8'h01) begin
          flash_q <= 8'h00;
          led_q <= ~led_q;
        end else begin
          flash_q <= flash_q + 8'h01;
        end
      end
    end
  end

  // interrupt events
  assign irq_set[err_resp_pkg::IRQ_WRONG_NODE] =
    ev & (code_w == err_resp_pkg::CODE_WRONG_NODE);
  assign irq_set[err_resp_pkg::IRQ_NO_REPLY] =
    ev & (code_w == err_resp_pkg::CODE_NO_REPLY);
  assign irq_set[err_resp_pkg::IRQ_EXCEPTION] =
    ev & (code_w == err_resp_pkg::CODE_EXCEPTION);
  assign irq_set[err_resp_pkg::IRQ_TX_FAIL] = can_tx_fail & ~fail_q;

  // sticky bits; a set in the clearing cycle wins
  genvar gi;
  for (gi = 0; gi < err_resp_pkg::IRQ_W; gi++) begin : g_irq
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        irq_stat_q[gi] <= 1'b0;
        irq_mask_q[gi] <= 1'b0;
      end else begin
        irq_stat_q[gi] <= irq_set[gi] | (irq_stat_q[gi] & ~w1c[gi]);
        if (wr && hit_imk) begin
          irq_mask_q[gi] <= pwdata[gi];
        end
      end
    end
  end

  // interrupt line lags status by one cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // outputs, each straight from a flop except can_tx_dlc, which is the constant FRAME_DLC
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign next_cmd = next_q;
  assign cmd_timed_out = tmo_q;
  assign can_tx_valid = tx_valid_q;
  assign can_tx_ext = tx_ext_q;
  assign can_tx_id = tx_id_q;
  assign can_tx_dlc = err_resp_pkg::FRAME_DLC;
  assign can_tx_data = tx_data_q;
  assign can_bit_rate = rate_act_q;
  assign bit_timing_word_zero = btw_act_q[7:0];
  assign bit_timing_word_one = btw_act_q[15:8];
  assign power_indicator_led = led_q;
  assign irq = irq_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_exc_code_sent: assert property (
    in_wait && reply_done && !node_bad && is_exc && en_act_q
    |=> tx_valid_q && tx_data_q[7:0] == err_resp_pkg::CODE_EXCEPTION)
    else $error("exception reply did not give code 03");
  a_detail_zero: assert property (
    tx_valid_q && tx_data_q[7:0] != err_resp_pkg::CODE_EXCEPTION
    |-> tx_data_q[63:32] == 32'h0)
    else $error("detail bytes not zero");
  a_exc_layout: assert property (
    in_wait && reply_done && !node_bad && is_exc && en_act_q
    |=> tx_data_q[39:32] == $past(reply_node) &&
    tx_data_q[55:48] == $past(reply_exc) && tx_data_q[63:56] == 8'h00)
    else $error("exception detail layout wrong");
  a_exc_func_bit: assert property (
    tx_valid_q && tx_data_q[7:0] == err_resp_pkg::CODE_EXCEPTION
    |-> tx_data_q[47] && tx_data_q[46:40] == func_q[6:0])
    else $error("exception function mismatch");
  a_timeout_next: assert property (
    tmo_hit && !en_act_q |=> tmo_q && next_q ##1 in_wait == 1'b0)
    else $error("timeout did not release next command");
  a_reload_only: assert property (
    wr && hit_ctrl && !reload |=> $stable(en_act_q))
    else $error("active setting changed without reload");
  a_led_steady: assert property (
    !can_tx_fail |=> led_q)
    else $error("indicator dark while can works");
  a_send_enabled: assert property (
    $rose(tx_valid_q) |-> $past(en_act_q) &&
    (tx_ext_q || tx_id_q[28:11] == 18'h0))
    else $error("frame sent disabled or id too wide");
  a_frame_reserved: assert property (
    tx_valid_q |-> tx_data_q[31:8] == 24'h0 && tx_data_q[7:0] != 8'h00)
    else $error("reserved bytes or code wrong");
  a_wrong_node: assert property (
    in_wait && reply_done && node_bad && en_act_q
    |=> tx_valid_q && tx_data_q[7:0] == err_resp_pkg::CODE_WRONG_NODE)
    else $error("wrong node not reported");
  a_timer_restart: assert property (
    state_q == err_resp_pkg::ST_IDLE && cmd_sent
    |=> ms_cnt_q == 16'h0 && ms_div_q == 16'h0)
    else $error("reply timer not restarted");

  c_exception: cover property (in_wait && reply_done && is_exc);
  c_timeout: cover property (tmo_hit);
  c_frame_taken: cover property (tx_valid_q && can_tx_ready);
  c_led_flash: cover property (can_tx_fail && $fell(led_q));

endmodule // modbus_can_error_response

// File: inc/err_resp_pkg.sv
package err_resp_pkg;
  // register byte offsets on the apb window
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ERR_ID = 8'h04;
  localparam logic [7:0] OFF_TIMEOUT = 8'h08;
  localparam logic [7:0] OFF_BIT_RATE = 8'h0c;
  localparam logic [7:0] OFF_BIT_TIMING = 8'h10;
  localparam logic [7:0] OFF_RELOAD = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int RELOAD_BIT = 0;
  localparam int IRQ_WRONG_NODE = 0;
  localparam int IRQ_NO_REPLY = 1;
  localparam int IRQ_EXCEPTION = 2;
  localparam int IRQ_TX_FAIL = 3;
  localparam int IRQ_W = 4;

  // reset values of staged and active settings
  localparam logic RST_EN = 1'b1;
  localparam logic RST_EXT = 1'b0;
  localparam logic [28:0] RST_ERR_ID = 29'h00007ff;
  localparam logic [15:0] RST_TIMEOUT_MS = 16'h0064;
  localparam logic [19:0] RST_BIT_RATE = 20'h14585;
  localparam logic [15:0] RST_BIT_TIMING = 16'h0000;

  // error frame contents
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_WRONG_NODE = 8'h01;
  localparam logic [7:0] CODE_NO_REPLY = 8'h02;
  localparam logic [7:0] CODE_EXCEPTION = 8'h03;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [3:0] FRAME_DLC = 4'h8;
  localparam logic [28:0] STD_ID_MASK = 29'h00007ff;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLASH_PERIOD_MS = 100;
  localparam logic [7:0] FLASH_HALF_MS = 8'(FLASH_PERIOD_MS / 2);

  // one-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b100
  } state_t;

  // function codes that have a defined exception twin
  function automatic logic fc_known(input logic [7:0] f);
    return (f >= 8'h01 && f <= 8'h06) || f == 8'h0f || f == 8'h10;
  endfunction
endpackage

// File: tb/slave_model.sv
// far side: serial slaves answering commands and a can node taking frames
module slave_model (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic cmd_sent, // command fully sent
  input wire logic [7:0] cmd_node, // addressed node
  input wire logic [7:0] cmd_func, // function of command
  input wire logic [1:0] mode, // 0 ok, 1 wrong node, 2 exception, 3 silent
  input wire logic [7:0] exc, // exception code to answer
  input wire logic slow, // can node stalls its ready
  input wire logic can_tx_valid, // frame offered
  output logic reply_done, // complete reply frame
  output logic [7:0] reply_node, // reply node byte
  output logic [7:0] reply_func, // reply function byte
  output logic [7:0] reply_exc, // reply exception code
  output logic can_tx_ready // frame taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy; // a reply is pending
  logic [3:0] dly; // reply delay count
  logic [7:0] node_l, func_l; // latched command
  logic [2:0] stall; // can stall counter
  // reply generator; fields toggle outside the reply so stale data shows
  always @(posedge mclk) begin
    reply_done <= 1'b0;
    reply_node <= ~reply_node;
    reply_func <= ~reply_func;
    reply_exc <= ~reply_exc;
    if (sys_rst) begin
      busy <= 1'b0;
      dly <= 4'h0;
    end else if (cmd_sent) begin
      busy <= (mode != 2'd3);
      node_l <= cmd_node;
      func_l <= cmd_func;
      dly <= 4'h5;
    end else if (busy && dly == 4'h0) begin
      busy <= 1'b0;
      reply_done <= 1'b1;
      reply_node <= (mode == 2'd1) ? node_l ^ 8'h01 : node_l;
      reply_func <= (mode == 2'd2) ? func_l | 8'h80 : func_l;
      reply_exc <= exc;
    end else if (dly != 4'h0) begin
      dly <= dly - 4'h1;
    end
  end
  // can node: prompt, or only every eighth cycle when slow
  always @(posedge mclk) begin
    stall <= can_tx_valid ? stall + 3'h1 : 3'h0;
    can_tx_ready <= can_tx_valid && (!slow || stall == 3'h7);
  end
endmodule // slave_model

// File: tb/modbus_can_error_response_bench.sv
module modbus_can_error_response_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, led;
  logic [7:0] paddr, cmd_node, cmd_func, reply_node, reply_func, reply_exc;
  logic [31:0] pwdata, prdata, rd;
  logic cmd_sent, reply_done, next_cmd, cmd_timed_out, slow, err;
  logic can_tx_ready, can_tx_fail, can_tx_valid, can_tx_ext, en_a, ext_a;
  logic [28:0] can_tx_id, id_a; // id_a: active id the bench expects
  logic [3:0] can_tx_dlc;
  logic [63:0] can_tx_data;
  logic [19:0] can_bit_rate;
  logic [7:0] tw0, tw1, exc;
  logic [1:0] mode;
  logic [93:0] exp_q[$]; // expected frames {ext, id, data}
  logic [7:0] fcs [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                          8'h0f, 8'h10};
  logic [7:0] ra [6] = '{8'h04, 8'h08, 8'h0c, 8'h20, 8'h00, 8'h24};
  logic [31:0] rv [6] = '{32'h7ff, 32'h64, 32'h14585, 32'h0, 32'h1, 32'h0};
  int num_errors = 0, total_checks = 0, seed = 32'h80bb, tmo, n;
  logic l0;

  modbus_can_error_response #(.ms_cycles(4)) u_dut (.mclk(mclk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_sent(cmd_sent), .cmd_node(cmd_node),
    .cmd_func(cmd_func), .reply_done(reply_done), .reply_node(reply_node),
    .reply_func(reply_func), .reply_exc(reply_exc), .next_cmd(next_cmd),
    .cmd_timed_out(cmd_timed_out), .can_tx_ready(can_tx_ready),
    .can_tx_fail(can_tx_fail), .can_tx_valid(can_tx_valid),
    .can_tx_ext(can_tx_ext), .can_tx_id(can_tx_id), .can_tx_dlc(can_tx_dlc),
    .can_tx_data(can_tx_data), .can_bit_rate(can_bit_rate),
    .bit_timing_word_zero(tw0), .bit_timing_word_one(tw1),
    .power_indicator_led(led), .irq(irq));

  slave_model u_far (.mclk(mclk), .sys_rst(sys_rst), .cmd_sent(cmd_sent),
    .cmd_node(cmd_node), .cmd_func(cmd_func), .mode(mode), .exc(exc),
    .slow(slow), .can_tx_valid(can_tx_valid), .reply_done(reply_done),
    .reply_node(reply_node), .reply_func(reply_func),
    .reply_exc(reply_exc), .can_tx_ready(can_tx_ready));

  // 40 mhz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // one comparison, counted
  task automatic chk(string what, logic [95:0] e, logic [95:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // apb transfer, held until pready is sampled high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk("pready", 1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one command; frame expectation noted before the command starts
  task automatic send(logic [1:0] m, logic [7:0] f, logic [7:0] code);
    logic [7:0] nd, x;
    logic [63:0] d;
    nd = 8'($random(seed));
    x = 8'($random(seed));
    d = {56'h0, code};
    if (code == 8'h03) d = {8'h00, x, f | 8'h80, nd, 24'h0, code};
    if (code != 8'h00 && en_a)
      exp_q.push_back({ext_a, ext_a ? id_a : id_a & 29'h7ff, d});
    @(posedge mclk);
    mode <= m;
    exc <= x;
    cmd_node <= nd;
    cmd_func <= f;
    cmd_sent <= 1'b1;
    @(posedge mclk);
    cmd_sent <= 1'b0;
    n = 0;
    tmo = 0;
    do begin
      @(posedge mclk);
      n++;
      if (cmd_timed_out === 1'b1) tmo = n;
    end while (next_cmd !== 1'b1 && n < 1000);
    chk("next_cmd", 1, next_cmd);
  endtask

  // frame monitor: oldest expectation against each accepted frame
  always @(posedge mclk) begin
    if (sys_rst === 1'b0 && can_tx_valid === 1'b1 && can_tx_ready === 1'b1)
      if (exp_q.size() == 0) chk("frame count", 0, 1);
      else begin
        chk("frame", exp_q.pop_front(), {can_tx_ext, can_tx_id,
          can_tx_data});
        chk("dlc", 8, can_tx_dlc);
      end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("ERROR watchdog expected end seen hang");
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, cmd_sent, cmd_node} = '0;
    {cmd_func, mode, exc, slow, can_tx_fail} = '0;
    {en_a, ext_a, id_a, sys_rst} = {1'b1, 1'b0, 29'h7ff, 1'b1};
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset read", rv[i], rd);
      chk("pslverr", i == 5, err);
    end
    chk("bit rate", 20'h14585, can_bit_rate);
    $display("test reset values done");
    apb(1'b1, 8'h20, 32'hf);
    foreach (fcs[i]) send(2'd2, fcs[i], 8'h03);
    send(2'd1, 8'h03, 8'h01);
    send(2'd0, 8'h06, 8'h00);
    slow <= 1'b1;
    send(2'd2, 8'h10, 8'h03);
    slow <= 1'b0;
    $display("test error frames done");
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h04, 32'h1abcdef5);
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b1, 8'h0c, 32'h1e848);
    apb(1'b1, 8'h10, 32'h1c05);
    send(2'd1, 8'h01, 8'h01);
    chk("staged rate", 20'h14585, can_bit_rate);
    apb(1'b1, 8'h14, 32'h1);
    // reload lands at the edge that ends the transfer; look one edge later
    @(posedge mclk);
    {ext_a, id_a} = {1'b1, 29'h1abcdef5};
    chk("bit rate", 20'h1e848, can_bit_rate);
    chk("timing", 16'h1c05, {tw1, tw0});
    send(2'd3, 8'h04, 8'h02);
    chk("timeout in window", 1, tmo >= 8 && tmo <= 10);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h14, 32'h1);
    en_a = 1'b0;
    send(2'd2, 8'h05, 8'h03);
    send(2'd3, 8'h02, 8'h02);
    $display("test settings done");
    apb(1'b0, 8'h1c, 32'h0);
    chk("irq status", 32'h7, rd);
    chk("irq", 1, irq);
    apb(1'b1, 8'h1c, 32'h7);
    repeat (2) @(posedge mclk);
    chk("irq cleared", 0, irq);
    can_tx_fail <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("irq fail", 1, irq);
    apb(1'b0, 8'h18, 32'h0);
    chk("status", 4'h4, rd[3:0]);
    for (int p = 0; p < 2; p++) begin
      l0 = led;
      n = 0;
      while (led === l0 && n < 400) begin
        @(posedge mclk);
        n++;
      end
    end
    chk("led half period", 200, n);
    can_tx_fail <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("led lit", 1, led);
    apb(1'b1, 8'h1c, 32'h8);
    repeat (2) @(posedge mclk);
    chk("irq off", 0, irq);
    chk("frames left", 0, exp_q.size());
    $display("test status and indicator done");
    wrap_up();
  end
endmodule // modbus_can_error_response_bench
